// >>> logic/tdd_pkg.sv
`default_nettype none
package tdd_pkg;
    // ************************************************************
    // clocking
    // ************************************************************
    localparam int CLK_KHZ = 100000; // ref_clk rate
    localparam int BASE_KHZ = 1125; // duty base clock rate
    localparam int QUARTERS = 4; // sub-steps per base count, for the quarter offset
    localparam int QTICK_KHZ = BASE_KHZ * QUARTERS;
    localparam int ACC_W = 17;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(QTICK_KHZ);
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_KHZ);
    localparam int QGAP_MIN = CLK_KHZ / QTICK_KHZ;
    localparam int CNT_W = 10; // 8-bit count plus 2 quarter bits
    localparam int NCH = 3;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_DUTY0 = 8'h05;
    localparam logic [7:0] ADDR_DUTY1 = 8'h06;
    localparam logic [7:0] ADDR_DUTY2 = 8'h07;
    localparam logic [6:0] ADDR_PINSEL = 7'h13;
    localparam int SEL_CGP_BIT = 0;
    localparam int SEL_CH0_BIT = 1;
    localparam logic [3:0] PINSEL_RST = 4'h0;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [1:0] QUARTER_OFS = 2'h1;
    // open-drain enables of the four pins
    typedef struct packed {
        logic clock_gen_port;
        logic [NCH-1:0] duty;
    } tdd_pins_t;
endpackage
`default_nettype wire

// >>> logic/tdd_dac.sv
`default_nettype none
module tdd_dac #(
    parameter int PHASE_Q = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // peripheral transfer, store and load instructions
    input wire logic bufStore,
    input wire logic bufLoad,
    input wire logic [7:0] periphAddr,
    input wire logic [15:0] transferBuffer,
    output logic [15:0] loadData,
    // register file access
    input wire logic rfWrite,
    input wire logic rfRead,
    input wire logic [6:0] rfAddr,
    input wire logic [3:0] rfWdata,
    output logic [3:0] rfRdata,
    // system states
    input wire logic clockStop,
    input wire logic ceReset,
    input wire logic halt,
    // plain output latches and clock-generator waveform
    input wire logic [3:0] portLatch,
    input wire logic clockGenWave,
    // open-drain pins, value always low, enable pulls low
    output tdd_pkg::tdd_pins_t pinOut,
    output tdd_pkg::tdd_pins_t pinOe
);
    import tdd_pkg::*;

    // refuse a negative skew, or one whose NCH times PHASE_Q would not fit the 10-bit counter
    if (PHASE_Q < 0 || PHASE_Q * NCH > 1023) begin : g_bad_phase
        $error("PHASE_Q out of range");
    end

    // ************************************************************
    // shared clock stage
    // ************************************************************
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] accSum;
    logic qTick;
    assign accSum = acc_q + ACC_STEP;
    assign qTick = (accSum >= ACC_MOD);

    // fractional divider: exact 4500 kHz average, jitter of one ref_clk
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_q <= '0;
        end else if (qTick) begin
            acc_q <= accSum - ACC_MOD;
        end else begin
            acc_q <= accSum;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [3:0] pinSel_q;
    logic [7:0] duty_q [NCH];
    logic [15:0] loadData_q;
    logic [3:0] rfRdata_q;

    // select flags; halt and ceReset deliberately have no effect here
    always_ff @(posedge ref_clk) begin
        if (rst || clockStop) begin
            pinSel_q <= PINSEL_RST;
        end else if (rfWrite && rfAddr == ADDR_PINSEL) begin
            pinSel_q <= rfWdata;
        end
    end

    // duty values survive clock stop and chip-enable reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                duty_q[i] <= DUTY_RST;
            end
        end else if (bufStore) begin
            for (int i = 0; i < NCH; i++) begin
                if (periphAddr == ADDR_DUTY0 + 8'(i)) begin
                    duty_q[i] <= transferBuffer[7:0];
                end
            end
        end
    end

    // load answers, unmapped addresses return zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            loadData_q <= '0;
        end else if (bufLoad) begin
            case (periphAddr)
                ADDR_DUTY0: loadData_q <= {8'h00, duty_q[0]};
                ADDR_DUTY1: loadData_q <= {8'h00, duty_q[1]};
                ADDR_DUTY2: loadData_q <= {8'h00, duty_q[2]};
                default: loadData_q <= '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rfRdata_q <= '0;
        end else if (rfRead) begin
            rfRdata_q <= (rfAddr == ADDR_PINSEL) ? pinSel_q : 4'h0;
        end
    end
    assign loadData = loadData_q;
    assign rfRdata = rfRdata_q;

    // ************************************************************
    // per-channel duty and output stages
    // ************************************************************
    logic [CNT_W-1:0] cnt_q [NCH];
    logic [NCH-1:0] high;
    logic [NCH-1:0] dutyOe_q;
    logic cgpOe_q;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        // counter in quarter counts, preset gives the fixed phase skew
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                cnt_q[c] <= CNT_W'(c * PHASE_Q);
            end else if (qTick) begin
                cnt_q[c] <= cnt_q[c] + CNT_W'(1);
            end
        end
        // comparing against x plus a quarter gives the offset for free
        assign high[c] = cnt_q[c] < {duty_q[c], QUARTER_OFS};

        // open drain: enable means pull low
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                dutyOe_q[c] <= 1'b0;
            end else if (pinSel_q[SEL_CH0_BIT + c]) begin
                dutyOe_q[c] <= ~high[c];
            end else begin
                dutyOe_q[c] <= ~portLatch[SEL_CH0_BIT + c];
            end
        end

        chk_pin_follows: assert property (@(posedge ref_clk) disable iff (rst)
            $past(pinSel_q[SEL_CH0_BIT + c]) |-> dutyOe_q[c] == !$past(high[c]))
            else $error("duty pin not following comparator");
        chk_gp_latch: assert property (@(posedge ref_clk) disable iff (rst)
            !$past(pinSel_q[SEL_CH0_BIT + c])
            |-> dutyOe_q[c] == !$past(portLatch[SEL_CH0_BIT + c]))
            else $error("plain pin not following latch");
        chk_cnt_step: assert property (@(posedge ref_clk) disable iff (rst)
            qTick |=> cnt_q[c] == $past(cnt_q[c]) + 10'h001)
            else $error("channel counter did not step");
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cgpOe_q <= 1'b0;
        end else begin
            cgpOe_q <= pinSel_q[SEL_CGP_BIT] ? ~clockGenWave : ~portLatch[SEL_CGP_BIT];
        end
    end

    assign pinOe = '{clock_gen_port: cgpOe_q, duty: dutyOe_q};
    assign pinOut = '0;

    // ************************************************************
    // checks
    // ************************************************************
    chk_qtick_gap: assert property (@(posedge ref_clk) disable iff (rst)
        qTick |-> ##[22:23] qTick)
        else $error("quarter tick spacing wrong");
    chk_qtick_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        qTick |=> !qTick [*8])
        else $error("quarter ticks too close");
    chk_stop_clears: assert property (@(posedge ref_clk) disable iff (rst)
        clockStop |=> pinSel_q == PINSEL_RST)
        else $error("clock stop kept select flags");
    chk_ce_keeps: assert property (@(posedge ref_clk) disable iff (rst)
        (ceReset || halt) && !clockStop && !rfWrite |=> $stable(pinSel_q))
        else $error("select flags changed in chip-enable reset");
    chk_duty_store: assert property (@(posedge ref_clk) disable iff (rst)
        bufStore && periphAddr == ADDR_DUTY1 |=> duty_q[1] == $past(transferBuffer[7:0]))
        else $error("duty store lost");
    chk_zero_quarter: assert property (@(posedge ref_clk) disable iff (rst)
        duty_q[0] == 8'h00 && cnt_q[0] == 10'h000 |-> high[0])
        else $error("zero duty lost quarter high");
    chk_quarter_end: assert property (@(posedge ref_clk) disable iff (rst)
        cnt_q[0] == {duty_q[0], QUARTER_OFS} |-> !high[0])
        else $error("high time too long");
    chk_phase_skew: assert property (@(posedge ref_clk) disable iff (rst)
        cnt_q[1] - cnt_q[0] == 10'(PHASE_Q))
        else $error("channel phase skew drifted");
endmodule // tdd_dac
`default_nettype wire

// >>> tb/tdd_pullup.sv
`default_nettype none
module tdd_pullup (
    // open-drain enables from the block
    input wire tdd_pkg::tdd_pins_t pinOe,
    // resolved levels, latch bit order: cgp, ch0..ch2
    output logic [3:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    import tdd_pkg::*;
    // pull-up wins unless the pin is pulled low, so no stale level
    assign pinLevel = {~pinOe.duty, ~pinOe.clock_gen_port};
endmodule // tdd_pullup
`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tdd_pkg::*;
    logic ref_clk = 0, rst = 1, bufStore = 0, bufLoad = 0, rfWrite = 0, rfRead = 0;
    logic clockStop = 0, ceReset = 0, halt = 0, clockGenWave = 0;
    logic [7:0] periphAddr = 8'h00;
    logic [15:0] transferBuffer = 16'h0000, loadData;
    logic [6:0] rfAddr = 7'h00;
    logic [3:0] rfWdata = 4'h0, rfRdata, portLatch = 4'hf, pinLevel;
    tdd_pins_t pinOut, pinOe;
    int badCount = 0, checksDone = 0, cycles = 0;
    int edges = 0;
    logic lastLvl = 1'b0;
    tdd_dac i_tdd_dac (.ref_clk(ref_clk), .rst(rst), .bufStore(bufStore), .bufLoad(bufLoad),
        .periphAddr(periphAddr), .transferBuffer(transferBuffer), .loadData(loadData),
        .rfWrite(rfWrite), .rfRead(rfRead), .rfAddr(rfAddr), .rfWdata(rfWdata),
        .rfRdata(rfRdata), .clockStop(clockStop), .ceReset(ceReset), .halt(halt),
        .portLatch(portLatch), .clockGenWave(clockGenWave), .pinOut(pinOut), .pinOe(pinOe));
    tdd_pullup i_tdd_pullup (.pinOe(pinOe), .pinLevel(pinLevel));
    // ****************************************
    // clock, watchdog and reporting
    // ****************************************
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // the run needs two and a half pwm periods, about 58k cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 70000) begin
            badCount++;
            stopTest();
        end
    end
    task automatic stopTest();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // ****************************************
    // access tasks, driven on the falling edge
    // ****************************************
    task automatic store(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        {bufStore, periphAddr, transferBuffer} = {1'b1, a, d};
        @(negedge ref_clk);
        bufStore = 0;
    endtask
    task automatic load(input logic [7:0] a, input logic [15:0] exp);
        @(negedge ref_clk);
        {bufLoad, periphAddr} = {1'b1, a};
        @(negedge ref_clk);
        bufLoad = 0;
        check(loadData, exp);
    endtask
    task automatic rfw(input logic [6:0] a, input logic [3:0] d);
        @(negedge ref_clk);
        {rfWrite, rfAddr, rfWdata} = {1'b1, a, d};
        @(negedge ref_clk);
        rfWrite = 0;
    endtask
    task automatic rfr(input logic [6:0] a, input logic [3:0] exp);
        @(negedge ref_clk);
        {rfRead, rfAddr} = {1'b1, a};
        @(negedge ref_clk);
        rfRead = 0;
        check(16'(rfRdata), 16'(exp));
    endtask
    // high cycles over two periods, tolerance covers tick jitter
    task automatic measure(input logic [7:0] d [3]);
        int hi [3];
        int exp;
        hi = '{0, 0, 0};
        repeat (45511) begin
            @(negedge ref_clk);
            for (int c = 0; c < 3; c++) hi[c] += int'(pinLevel[c+1]);
        end
        for (int c = 0; c < 3; c++) begin
            exp = (4 * int'(d[c]) + 1) * 400 / 9;
            check(16'(hi[c] >= exp - 30 && hi[c] <= exp + 30), 16'h0001);
        end
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        rst = 0;
        rfr(7'h13, 4'h0);
        rfr(7'h12, 4'h0);
        store(8'h05, 16'ha500);
        store(8'h06, 16'h5a80);
        store(8'h07, 16'h3cff);
        store(8'h08, 16'h0011);
        load(8'h05, 16'h0000);
        load(8'h06, 16'h0080);
        load(8'h07, 16'h00ff);
        load(8'h08, 16'h0000);
        rfw(7'h13, 4'he);
        rfr(7'h13, 4'he);
        measure('{8'h00, 8'h80, 8'hff});
        {ceReset, halt} = 2'b11;
        rfr(7'h13, 4'he);
        // ch1 at half duty must keep toggling; no stretch is longer than 12k cycles
        lastLvl = pinLevel[2];
        repeat (12000) begin
            @(negedge ref_clk);
            if (pinLevel[2] != lastLvl) edges++;
            lastLvl = pinLevel[2];
        end
        check(16'(edges > 0), 16'h0001);
        {ceReset, halt, clockStop} = 3'b001;
        @(negedge ref_clk);
        clockStop = 0;
        rfr(7'h13, 4'h0);
        load(8'h06, 16'h0080);
        portLatch = 4'b1010;
        repeat (3) @(negedge ref_clk);
        check(16'(pinLevel), 16'h000a);
        rfw(7'h13, 4'h1);
        clockGenWave = 1;
        repeat (3) @(negedge ref_clk);
        check(16'(pinLevel), 16'h000b);
        clockGenWave = 0;
        repeat (3) @(negedge ref_clk);
        check(16'(pinLevel), 16'h000a);
        check(16'(pinOut), 16'h0000);
        stopTest();
    end
endmodule // tb
`default_nettype wire
